/* File: hw/sep_consts.vh */
`ifndef SEP_CONSTS_VH
`define SEP_CONSTS_VH
`define SEP_OP_SPECIAL      2'h0
`define SEP_OP_WRITE        2'h1
`define SEP_OP_READ         2'h2
`define SEP_OP_ERASE        2'h3
`define SEP_EXT_LOCK        2'h0
`define SEP_EXT_WRALL       2'h1
`define SEP_EXT_ERALL       2'h2
`define SEP_EXT_UNLOCK      2'h3
`define SEP_PROG_TIME_MS    10
`define SEP_CLK_MHZ         125
`define SEP_PROG_CYCLES     (`SEP_PROG_TIME_MS * 1000 * `SEP_CLK_MHZ)
`define SEP_FIFO_DEPTH      16
`endif

/* File: hw/sep_top.v */
// Function
// - Host bits are sampled on each rising serial clock edge.
// - Data output floats except during read data or busy status.
// - After a program cycle starts, selected output shows low busy, high ready.
// - A 1 shifted in while status is shown floats the output.
// - Instruction: start bit 1, 2-bit opcode, address, data for writes.
// - Instruction length follows variant and word width selection.
// - Write data is 16 or 8 bits, right after the address.
// - Opcode 10 reads, 11 erases, 01 writes the addressed word.
// - Opcode 00: top address bits 11 unlock, 00 lock, 10 erase all, 01 write all.
// - Read: after address, drive a leading zero, then word MSB first.
// - Each read output bit launches on a rising serial clock edge.
// - Continued clocks stream next words, wrapping to address zero.
// - Only the first word of a burst has the leading zero.
// - Write latch is cleared at reset; writes need an unlock first.
// - Latch holds until lock; while cleared, writes and erases are blocked.
// - Reads work whatever the latch state.
// - Deselect after a write starts a self-timed clear and store.
// - The self-timed cycle needs no serial clock edges.
// - Writes clear the word automatically before storing.
// - Erase then deselect sets the addressed word to all ones.
// - Erase all then deselect sets every word to all ones.
// - Write all then deselect stores the data in every word.
`timescale 1ns/1ns
`default_nettype none
`include "sep_consts.vh"

module sep_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset
	input  wire             sys_clk_in,
	input  wire             nrst_in,
	input  wire             clr_in,
	// Fill side
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	// Drain side
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wr_ff;
	reg [AW-1:0]    rd_ff;
	reg [AW:0]      cnt_ff;
	wire            do_wr;
	wire            do_rd;

	assign in_ready_out  = (cnt_ff != DEPTH[AW:0]);
	assign out_valid_out = (cnt_ff != {(AW+1){1'b0}});
	assign out_data_out  = mem_ff[rd_ff];
	assign do_wr         = in_valid_in & in_ready_out;
	assign do_rd         = out_valid_out & out_ready_in;

	always @(posedge sys_clk_in) begin
		if (!nrst_in || clr_in) begin
			wr_ff  <= {AW{1'b0}};
			rd_ff  <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				mem_ff[wr_ff] <= in_data_in;
				wr_ff         <= wr_ff + 1'b1;
			end
			if (do_rd)
				rd_ff <= rd_ff + 1'b1;
			if (do_wr && !do_rd)
				cnt_ff <= cnt_ff + 1'b1;
			else if (do_rd && !do_wr)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule

module sep_top #(
	parameter LARGE_VARIANT = 1,
	parameter PROG_CYCLES   = `SEP_PROG_CYCLES
) (
	// Clock and reset
	input  wire sys_clk_in,
	input  wire nrst_in,
	// Serial link, sampled synchronously
	input  wire device_select_in,
	input  wire serial_clock_in,
	input  wire serial_data_in,
	input  wire word_width_select_in,
	// Serial output, three-state as data and enable
	output reg  serial_data_out,
	output reg  serial_data_oe_out,
	// Busy flag
	output reg  busy_out
);
	localparam ST_IDLE = 3'h0;
	localparam ST_CMD  = 3'h1;
	localparam ST_READ = 3'h2;
	localparam ST_DONE = 3'h3;
	localparam ST_STAT = 3'h4;

	// Address width: x16 gives 7 or 8 bits, x8 one more
	wire [3:0] addr_bits = (LARGE_VARIANT ? 4'h8 : 4'h7) + {3'h0, ~word_width_select_in};
	wire [4:0] data_bits = word_width_select_in ? 5'h10 : 5'h08;

	reg  [15:0] mem_ff [0:255];
	reg  [2:0]  state_ff;
	reg  [5:0]  bitcnt_ff;
	reg  [26:0] shift_ff;
	reg         sclk_d_ff;
	reg         wen_ff;
	reg  [7:0]  addr_ff;
	reg  [15:0] wdata_ff;
	reg  [1:0]  pend_ff;
	reg         pend_v_ff;
	reg  [31:0] timer_ff;
	reg  [4:0]  rbit_ff;
	reg  [8:0]  fill_ff;
	reg  [7:0]  prefetch_ff;
	reg  [1:0]  op_ff;
	reg  [1:0]  ext_ff;

	wire sclk_rise = serial_clock_in & ~sclk_d_ff;
	wire [26:0] nxt_shift = {shift_ff[25:0], serial_data_in};
	wire [5:0]  nxt_cnt = bitcnt_ff + 6'h01;
	wire [5:0]  hdr_len = 6'h03 + {2'h0, addr_bits};
	// Opcode sits just above the address at header end; extension is its top two bits
	wire [1:0]  hdr_op = nxt_shift[addr_bits + 4'h1 -: 2];
	wire [1:0]  hdr_ext = nxt_shift[addr_bits - 4'h1 -: 2];
	wire        hdr_wr = (hdr_op == `SEP_OP_WRITE) ||
		(hdr_op == `SEP_OP_SPECIAL && hdr_ext == `SEP_EXT_WRALL);
	wire [5:0]  data_len = hdr_len + {1'b0, data_bits};
	wire [7:0]  addr_mask = (LARGE_VARIANT ? 8'hFF : 8'h7F) >> word_width_select_in;
	wire [7:0]  hdr_addr = nxt_shift[7:0] & addr_mask;

	// Read words flow through a FIFO prefetched from memory
	wire        f_in_ready;
	wire        f_out_valid;
	wire [15:0] f_out_data;
	reg         f_take;
	wire        f_push = (state_ff == ST_READ) && (fill_ff != 9'h000) && f_in_ready;
	sep_fifo #(
		.WIDTH (16),
		.DEPTH (`SEP_FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.sys_clk_in    (sys_clk_in),
		.nrst_in       (nrst_in),
		.clr_in        (state_ff != ST_READ),
		.in_valid_in   (f_push),
		.in_ready_out  (f_in_ready),
		.in_data_in    (mem_ff[prefetch_ff]),
		.out_valid_out (f_out_valid),
		.out_ready_in  (f_take),
		.out_data_out  (f_out_data)
	);

	integer i;
	always @(posedge sys_clk_in) begin
		f_take <= 1'b0;
		if (!nrst_in) begin
			state_ff           <= ST_IDLE;
			bitcnt_ff          <= 6'h00;
			shift_ff           <= 27'h0000000;
			sclk_d_ff          <= 1'b0;
			wen_ff             <= 1'b0;
			addr_ff            <= 8'h00;
			wdata_ff           <= 16'h0000;
			pend_ff            <= 2'h0;
			pend_v_ff          <= 1'b0;
			timer_ff           <= 32'h00000000;
			rbit_ff            <= 5'h00;
			op_ff              <= 2'h0;
			ext_ff             <= 2'h0;
			fill_ff            <= 9'h000;
			prefetch_ff        <= 8'h00;
			serial_data_out    <= 1'b0;
			serial_data_oe_out <= 1'b0;
			busy_out           <= 1'b0;
		end else begin
			sclk_d_ff <= serial_clock_in;
			// Self-timed cycle runs on the system clock alone
			if (timer_ff != 32'h00000000) begin
				timer_ff <= timer_ff - 32'h00000001;
				if (timer_ff == 32'h00000001) begin
					busy_out <= 1'b0;
					case (pend_ff)
					2'h0: mem_ff[addr_ff] <= wdata_ff;
					2'h1: mem_ff[addr_ff] <= 16'hFFFF;
					2'h2: begin
						for (i = 0; i < 256; i = i + 1)
							mem_ff[i] <= 16'hFFFF;
					end
					default: begin
						for (i = 0; i < 256; i = i + 1)
							mem_ff[i] <= wdata_ff;
					end
					endcase
				end
			end
			if (f_push) begin
				prefetch_ff <= (prefetch_ff + 8'h01) & addr_mask;
				fill_ff     <= fill_ff - 9'h001;
			end
			if (!device_select_in) begin
				// Deselect drops partial frames and starts latched cycles
				state_ff           <= ST_IDLE;
				bitcnt_ff          <= 6'h00;
				serial_data_oe_out <= 1'b0;
				if (pend_v_ff) begin
					pend_v_ff <= 1'b0;
					timer_ff  <= PROG_CYCLES;
					busy_out  <= 1'b1;
				end
			end else begin
				case (state_ff)
				ST_IDLE: begin
					if (busy_out || timer_ff != 32'h00000000) begin
						state_ff <= ST_STAT;
					end else if (sclk_rise && serial_data_in) begin
						state_ff  <= ST_CMD;
						bitcnt_ff <= 6'h01;
						shift_ff  <= 27'h0000001;
					end
				end
				ST_STAT: begin
					// Status shows live busy level until a 1 is clocked in
					serial_data_oe_out <= 1'b1;
					serial_data_out    <= ~busy_out;
					if (sclk_rise && serial_data_in) begin
						serial_data_oe_out <= 1'b0;
						state_ff           <= ST_DONE;
					end
				end
				ST_CMD: begin
					if (sclk_rise) begin
						shift_ff  <= nxt_shift;
						bitcnt_ff <= nxt_cnt;
						if (nxt_cnt == hdr_len) begin
							// Latch the header; data bits shift it out of place later
							op_ff   <= hdr_op;
							ext_ff  <= hdr_ext;
							addr_ff <= hdr_addr;
							if (hdr_op == `SEP_OP_READ) begin
								state_ff           <= ST_READ;
								serial_data_oe_out <= 1'b1;
								serial_data_out    <= 1'b0;
								rbit_ff            <= 5'h00;
								prefetch_ff        <= hdr_addr;
								fill_ff            <= 9'h100;
							end else if (!hdr_wr) begin
								state_ff <= ST_DONE;
								if (hdr_op == `SEP_OP_SPECIAL && hdr_ext == `SEP_EXT_UNLOCK)
									wen_ff <= 1'b1;
								else if (hdr_op == `SEP_OP_SPECIAL && hdr_ext == `SEP_EXT_LOCK)
									wen_ff <= 1'b0;
								else if (wen_ff) begin
									pend_v_ff <= 1'b1;
									pend_ff   <= (hdr_op == `SEP_OP_ERASE) ? 2'h1 : 2'h2;
								end
							end
						end else if (nxt_cnt == data_len) begin
							state_ff <= ST_DONE;
							wdata_ff <= word_width_select_in ? nxt_shift[15:0]
								: {8'h00, nxt_shift[7:0]};
							if (wen_ff) begin
								pend_v_ff <= 1'b1;
								pend_ff   <= (op_ff == `SEP_OP_WRITE) ? 2'h0 : 2'h3;
							end
						end
					end
				end
				ST_READ: begin
					// Each word goes out MSB first, back to back
					if (sclk_rise && f_out_valid) begin
						serial_data_out <= (word_width_select_in ?
							f_out_data[15 - rbit_ff[3:0]] : f_out_data[7 - rbit_ff[2:0]]);
						if (rbit_ff == data_bits - 5'h01) begin
							rbit_ff <= 5'h00;
							f_take  <= 1'b1;
							fill_ff <= 9'h100;
						end else begin
							rbit_ff <= rbit_ff + 5'h01;
						end
					end
				end
				default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/sep_host.sv */
`timescale 1ns/1ns
`default_nettype none
module sep_host (
	// Clock and link
	input  wire logic clk_in,
	input  wire logic dout_in,
	output var  logic cs_out,
	output var  logic sk_out,
	output var  logic di_out
);
	initial {cs_out, sk_out, di_out} = 3'h0;
	// Bit set in low phase, taken on the rise
	task automatic bit_io(logic b);
		di_out <= b;
		repeat (8) @(posedge clk_in);
		sk_out <= 1'h1;
		repeat (8) @(posedge clk_in);
		sk_out <= 1'h0;
		repeat (8) @(posedge clk_in);
	endtask
	task automatic frame(int n, logic [26:0] v);
		cs_out <= 1'h1;
		for (int i = 26; i > 26 - n; i--)
			bit_io(v[i]);
		repeat (8) @(posedge clk_in);
	endtask
	// Clock stays low; cycle runs unclocked
	task automatic desel();
		cs_out <= 1'h0;
		di_out <= ~di_out;
		repeat (32) @(posedge clk_in);
	endtask
	task automatic rd(output logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			bit_io(1'h0);
			w[i] = dout_in;
		end
	endtask
endmodule
`default_nettype wire

/* File: tb/sep_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module sep_top_bench;
	logic sys_clk_in = 1'h0;
	logic nrst_in = 1'h0;
	logic cs, sk, di, dout, oe, busy;
	logic [15:0] w;
	int err_count = 0;
	int n_compared = 0;
	always #4 sys_clk_in = ~sys_clk_in;
	sep_host u_host (.clk_in(sys_clk_in), .dout_in(dout), .cs_out(cs), .sk_out(sk), .di_out(di));
	// Short cycle keeps the run brief
	sep_top #(.PROG_CYCLES(200)) u_dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.device_select_in(cs), .serial_clock_in(sk), .serial_data_in(di),
		.word_width_select_in(1'h1), .serial_data_out(dout), .serial_data_oe_out(oe),
		.busy_out(busy));
	task automatic chk(logic [15:0] s, logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Start bit, opcode, address, data
	task automatic run(logic [1:0] op, logic [7:0] a, logic [15:0] d, int n);
		u_host.frame(n, {1'h1, op, a, d});
		u_host.desel();
	endtask
	task automatic idle();
		for (int i = 0; i < 400 && busy !== 1'h0; i++)
			@(posedge sys_clk_in);
		if (busy !== 1'h0) begin
			err_count++;
			end_of_test();
		end
	endtask
	task automatic rd(logic [7:0] a, logic [15:0] e0, logic [15:0] e1);
		u_host.frame(11, {1'h1, 2'h2, a, 16'h0});
		chk({oe, dout}, 2'h2);
		u_host.rd(w);
		chk(w, e0);
		u_host.rd(w);
		chk(w, e1);
		u_host.desel();
	endtask
	task automatic s_write();
		run(2'h1, 8'h10, 16'h1234, 27);
		chk(busy, 1'h0);
		run(2'h0, 8'hC0, 16'h0, 11);
		run(2'h1, 8'h7F, 16'hA5C3, 27);
		chk(busy, 1'h1);
		u_host.frame(0, 27'h0);
		chk({oe, dout}, 2'h2);
		idle();
		repeat (2) @(posedge sys_clk_in);
		chk({oe, dout}, 2'h3);
		u_host.bit_io(1'h1);
		chk(oe, 1'h0);
		u_host.desel();
		run(2'h1, 8'h00, 16'h3C5A, 27);
		idle();
		rd(8'h7F, 16'hA5C3, 16'h3C5A);
	endtask
	task automatic s_protect();
		run(2'h3, 8'h7F, 16'h0, 11);
		idle();
		run(2'h0, 8'h00, 16'h0, 11);
		run(2'h1, 8'h00, 16'h1111, 27);
		chk(busy, 1'h0);
		rd(8'h7F, 16'hFFFF, 16'h3C5A);
	endtask
	// Aborted header must not shift the next one
	task automatic s_all();
		u_host.frame(5, {5'h14, 22'h0});
		u_host.desel();
		chk(oe, 1'h0);
		run(2'h0, 8'hC0, 16'h0, 11);
		run(2'h0, 8'h40, 16'h5A5A, 27);
		idle();
		rd(8'h10, 16'h5A5A, 16'h5A5A);
		run(2'h0, 8'h80, 16'h0, 11);
		idle();
		rd(8'h10, 16'hFFFF, 16'hFFFF);
	endtask
	initial begin
		repeat (20) @(posedge sys_clk_in);
		nrst_in <= 1'h1;
		@(posedge sys_clk_in);
		s_write();
		s_protect();
		s_all();
		end_of_test();
	end
endmodule
`default_nettype wire

/* File: tb/sep_top_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module sep_top_sva #(
	parameter PROG_CYCLES = 200
) (
	// Clock
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// Link
	input wire logic device_select_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	// Out
	input wire logic serial_data_out,
	input wire logic serial_data_oe_out,
	input wire logic busy_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	logic st_ff;
	int   cnt_ff;
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in || !device_select_in)
			st_ff <= 1'h0;
		else if ($rose(device_select_in) && busy_out)
			st_ff <= 1'h1;
		cnt_ff <= busy_out ? cnt_ff + 1 : 0;
	end
	sequence s_dummy; device_select_in && serial_data_in && $rose(serial_clock_in); endsequence
	property p_float; !device_select_in [*3] |-> !serial_data_oe_out; endproperty
	a_float: assert property (p_float) else $error("driven idle");
	property p_sel; $rose(serial_data_oe_out) |-> $past(device_select_in); endproperty
	a_sel: assert property (p_sel) else $error("no select");
	property p_busy; $rose(busy_out) |-> !$past(device_select_in); endproperty
	a_busy: assert property (p_busy) else $error("early cycle");
	property p_len; $fell(busy_out) |-> cnt_ff inside {[PROG_CYCLES - 1:PROG_CYCLES + 1]}; endproperty
	a_len: assert property (p_len) else $error("cycle length");
	property p_stat; $rose(device_select_in) && busy_out
		|-> ##[1:3] serial_data_oe_out && !serial_data_out; endproperty
	a_stat: assert property (p_stat) else $error("no busy");
	property p_rdy; st_ff && !busy_out && !$past(busy_out, 2) && serial_data_oe_out
		|-> serial_data_out; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_dis; st_ff ##0 s_dummy |-> ##[1:2] !serial_data_oe_out; endproperty
	a_dis: assert property (p_dis) else $error("no float");
	property p_bit; !st_ff && serial_data_oe_out && $past(serial_data_oe_out)
		&& $changed(serial_data_out) |-> $past(serial_clock_in)
		&& (!$past(serial_clock_in, 2) || !$past(serial_clock_in, 3)); endproperty
	a_bit: assert property (p_bit) else $error("bit off edge");
endmodule
bind sep_top sep_top_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.sys_clk_in(sys_clk_in),
	.nrst_in(nrst_in), .device_select_in(device_select_in), .busy_out(busy_out),
	.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
	.serial_data_out(serial_data_out), .serial_data_oe_out(serial_data_oe_out));
`default_nettype wire
